// file: hdl/fbpi_map.svh
// Constants for the flash bus pin interface.
// Summary of operation
// - Word address 21, 22 or 23 bits wide
// - Data bus: writes in, reads out
// - Data bus floats when deselected or disabled
// - Write data latched inside each write
// - Address latched on strobe rise or clock in sync mode; async mode passes the bus address straight through
// - Clock advances address counter, selectable edge
// - Chip enable activates internal logic
// - Deselect means standby, all outputs floating
// - Data driven only while output enable low
// - Reset holds automation, rejects writes
// - Reset forces asynchronous read-array; after release sync_mode sets the mode
// - Wait shows valid data, polarity bit 10
// - Wait floats on deselect, ignores output enable
// - Address and data taken at write strobe rise
// - Write protect blocks unlocking locked-down blocks
`ifndef FBPI_MAP_SVH
`define FBPI_MAP_SVH
`define FBPI_ADDR_W_SMALL 21
`define FBPI_ADDR_W_MID 22
`define FBPI_ADDR_W_LARGE 23
`define FBPI_DATA_W 16
`define FBPI_RCR_WAIT_POL_BIT 10
`define FBPI_RCR_RESET 16'h0000
`define FBPI_WAIT_LAT 2'h2
`endif

// file: hdl/fbpi_pkg.sv
// Types for the flash bus pin interface.
package fbpi_pkg;
  typedef enum logic [1:0] {
    FBPI_ASYNC_READ = 2'b00,
    FBPI_SYNC_READ  = 2'b01
  } fbpi_mode_t;
endpackage

// file: hdl/fbpi_edge.sv
// Edge detector for one sampled pin.
module fbpi_edge (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic prev;
  logic next_prev;

  always_comb
  begin
    next_prev = pin;
  end

  // The history follows the pin through reset, so no false edge appears whatever the idle level is.
  always_ff @(posedge clock)
  begin
    prev <= next_prev;
  end

  assign rise = pin & ~prev & ~srst;
  assign fall = ~pin & prev & ~srst;
endmodule // fbpi_edge

// file: hdl/fbpi_top.sv
// Pin-side control logic of the flash bus interface.
`include "fbpi_map.svh"
module fbpi_top #(
  parameter int ADDR_W = `FBPI_ADDR_W_LARGE
) (
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [15:0]       data_in,
  output logic      [15:0]       data_out,
  output logic                   data_oe,
  input  wire logic              addr_valid_n,
  input  wire logic              chip_en_n,
  input  wire logic              out_en_n,
  input  wire logic              write_en_n,
  input  wire logic              write_prot_n,
  input  wire logic              reset_n,
  input  wire logic              bus_clk,
  input  wire logic              clk_fall_sel,
  input  wire logic              sync_mode,
  input  wire logic [15:0]       array_data,
  output logic      [ADDR_W-1:0] array_addr,
  output logic      [ADDR_W-1:0] wr_addr,
  output logic      [15:0]       wr_data,
  output logic                   wr_strobe,
  output logic                   lockdown_ok,
  output logic                   active,
  output logic                   wait_out,
  output logic                   wait_oe
);
  logic                  addr_valid_rise;
  logic                  addr_valid_fall;
  logic                  clk_rise;
  logic                  clk_fall;
  logic                  we_rise;
  logic                  we_fall;
  logic                  clk_act;
  logic                  in_reset;
  logic                  sel;
  fbpi_pkg::fbpi_mode_t  mode;
  fbpi_pkg::fbpi_mode_t  next_mode;
  logic [ADDR_W-1:0]     cnt;
  logic [ADDR_W-1:0]     next_cnt;
  logic                  latched;
  logic                  next_latched;
  logic [1:0]            lat;
  logic [1:0]            next_lat;
  logic [15:0]           rcr;
  logic [15:0]           next_rcr;
  logic [15:0]           next_rd;
  logic [ADDR_W-1:0]     next_wr_addr;
  logic [15:0]           next_wr_data;
  logic                  next_wr_strobe;

  fbpi_edge u_addr_valid (.clock(clock), .srst(srst), .pin(addr_valid_n), .rise(addr_valid_rise),
    .fall(addr_valid_fall));
  fbpi_edge u_clk (.clock(clock), .srst(srst), .pin(bus_clk), .rise(clk_rise), .fall(clk_fall));
  fbpi_edge u_we  (.clock(clock), .srst(srst), .pin(write_en_n), .rise(we_rise), .fall(we_fall));

  assign in_reset = ~reset_n;
  assign sel = ~chip_en_n & ~in_reset;
  assign active = sel;
  assign clk_act = clk_fall_sel ? clk_fall : clk_rise;
  assign lockdown_ok = write_prot_n;

  always_comb
  begin
    next_mode = mode;
    next_cnt = cnt;
    next_latched = latched;
    next_lat = lat;
    next_rcr = rcr;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strobe = 1'b0;
    if (in_reset)
    begin
      next_mode = fbpi_pkg::FBPI_ASYNC_READ;
      next_latched = 1'b0;
      next_lat = 2'h0;
      next_rcr = `FBPI_RCR_RESET;
    end
    else if (sel)
    begin
      next_mode = sync_mode ? fbpi_pkg::FBPI_SYNC_READ : fbpi_pkg::FBPI_ASYNC_READ;
      // A strobe fall opens a new access; clearing first lets a latch in the same cycle win.
      if (addr_valid_fall)
        next_latched = 1'b0;
      // latch at strobe rise or clock
      if (mode == fbpi_pkg::FBPI_SYNC_READ && (!latched || addr_valid_fall)
          && (addr_valid_rise || (clk_act && !addr_valid_n)))
      begin
        next_cnt = addr;
        next_latched = 1'b1;
        next_lat = 2'h0;
      end
      else if (mode == fbpi_pkg::FBPI_SYNC_READ && latched && !addr_valid_fall && clk_act)
      begin
        if (lat != `FBPI_WAIT_LAT)
          next_lat = lat + 2'h1;
        else
          next_cnt = cnt + ADDR_W'(1);
      end
      if (we_rise)
      begin
        next_wr_addr = addr;
        next_wr_data = data_in;
        next_wr_strobe = 1'b1;
        // Configuration uses the address as data in this simplified model.
        if (addr == '0 && data_in == 16'h0060)
          next_rcr = rcr;
        else if (data_in == 16'h0003)
          next_rcr = addr[15:0];
      end
    end
    else
      next_latched = 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      mode <= fbpi_pkg::FBPI_ASYNC_READ;
      cnt <= '0;
      latched <= 1'b0;
      lat <= 2'h0;
      rcr <= `FBPI_RCR_RESET;
      wr_addr <= '0;
      wr_data <= 16'h0000;
      wr_strobe <= 1'b0;
      data_out <= 16'h0000;
    end
    else
    begin
      mode <= next_mode;
      cnt <= next_cnt;
      latched <= next_latched;
      lat <= next_lat;
      rcr <= next_rcr;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strobe <= next_wr_strobe;
      data_out <= next_rd;
    end
  end

  assign array_addr = (mode == fbpi_pkg::FBPI_SYNC_READ) ? cnt : addr;
  assign next_rd = array_data;
  assign data_oe = sel & ~out_en_n & write_en_n;
  assign wait_out = rcr[`FBPI_RCR_WAIT_POL_BIT] ~^ ~(mode == fbpi_pkg::FBPI_SYNC_READ && latched
                    && lat == `FBPI_WAIT_LAT);
  assign wait_oe = sel;

  AST_DATA_FLOAT: assert property (@(posedge clock) disable iff (srst) chip_en_n |-> !data_oe)
    else $error("data driven while deselected");
  AST_OE_GATE: assert property (@(posedge clock) disable iff (srst) out_en_n |-> !data_oe)
    else $error("data driven with output enable high");
  AST_WAIT_FLOAT: assert property (@(posedge clock) disable iff (srst) chip_en_n |-> !wait_oe)
    else $error("wait driven while deselected");
  AST_STANDBY: assert property (@(posedge clock) disable iff (srst) chip_en_n |-> !active && !data_oe)
    else $error("active while deselected");
  AST_NO_WR_RST: assert property (@(posedge clock) disable iff (srst) !reset_n |=> !wr_strobe)
    else $error("write accepted in reset");
  AST_RST_MODE: assert property (@(posedge clock) disable iff (srst)
    !reset_n |=> mode == fbpi_pkg::FBPI_ASYNC_READ)
    else $error("mode not async after reset");
  AST_WR_CAP: assert property (@(posedge clock) disable iff (srst)
    (we_rise && sel) |=> wr_strobe && wr_data == $past(data_in))
    else $error("write data not captured");
  AST_ADDR_LATCH: assert property (@(posedge clock) disable iff (srst)
    (sel && mode == fbpi_pkg::FBPI_SYNC_READ && !latched && addr_valid_rise) |=> cnt == $past(addr))
    else $error("address not latched");
  AST_CNT_STEP: assert property (@(posedge clock) disable iff (srst)
    (sel && mode == fbpi_pkg::FBPI_SYNC_READ && latched && !addr_valid_fall && clk_act
    && lat == `FBPI_WAIT_LAT) |=> cnt == ADDR_W'($past(cnt) + 1'b1))
    else $error("counter did not advance");
  AST_CNT_HOLD: assert property (@(posedge clock) disable iff (srst)
    (!clk_act && !addr_valid_rise) |=> $stable(cnt))
    else $error("counter moved without a clock edge");
  AST_WAIT_VALID: assert property (@(posedge clock) disable iff (srst)
    (mode == fbpi_pkg::FBPI_SYNC_READ && latched && lat == `FBPI_WAIT_LAT)
    |-> wait_out != rcr[`FBPI_RCR_WAIT_POL_BIT])
    else $error("wait not asserted on valid data");
  AST_WAIT_IDLE: assert property (@(posedge clock) disable iff (srst)
    !latched |-> wait_out == rcr[`FBPI_RCR_WAIT_POL_BIT])
    else $error("wait asserted without valid data");
  AST_ASYNC_ADDR: assert property (@(posedge clock) disable iff (srst)
    mode == fbpi_pkg::FBPI_ASYNC_READ |-> array_addr == addr)
    else $error("array address differs from bus address");
  AST_READ_DATA: assert property (@(posedge clock) disable iff (srst)
    1'b1 |=> data_out == $past(array_data))
    else $error("read data not forwarded");
  AST_WR_HOLD: assert property (@(posedge clock) disable iff (srst)
    !we_rise |=> $stable(wr_data) && $stable(wr_addr))
    else $error("write latch changed without a write");
  AST_ACTIVE: assert property (@(posedge clock) disable iff (srst) (!chip_en_n && reset_n) |-> active)
    else $error("not active when selected");

  COV_READ: cover property (@(posedge clock) disable iff (srst) data_oe ##1 data_oe);
  COV_WRITE: cover property (@(posedge clock) disable iff (srst) wr_strobe);
  COV_SYNC: cover property (@(posedge clock) disable iff (srst) latched && clk_act);
  COV_WAIT: cover property (@(posedge clock) disable iff (srst) wait_oe && latched && lat == `FBPI_WAIT_LAT);
endmodule // fbpi_top

// file: verif/fbpi_host.sv
// Host controller model for the select, read-enable, address and write pins of the flash bus.
module fbpi_host (
  input  wire logic clock,
  output logic [22:0] addr,
  output logic [15:0] data_in,
  output logic        chip_en_n,
  output logic        out_en_n,
  output logic        write_en_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    addr = 23'h000000;
    data_in = 16'h0000;
    chip_en_n = 1'b1;
    out_en_n = 1'b1;
    write_en_n = 1'b1;
  end
  task automatic sel(input logic ce, input logic oe);
    @(posedge clock);
    chip_en_n <= ce;
    out_en_n <= oe;
  endtask
  task automatic adr(input logic [22:0] a);
    @(posedge clock);
    addr <= a;
  endtask
  // valid before strobe rise, output enable off
  task automatic wr(input logic [22:0] a, input logic [15:0] d);
    @(posedge clock);
    out_en_n <= 1'b1;
    chip_en_n <= 1'b0;
    addr <= a;
    data_in <= d;
    write_en_n <= 1'b0;
    repeat (2) @(posedge clock);
    write_en_n <= 1'b1;
    repeat (2) @(posedge clock);
    // Hold time is over, so the data lines stop showing the old word.
    data_in <= ~d;
    // One more edge lets anything counted at the strobe settle before the caller looks.
    @(posedge clock);
  endtask
endmodule // fbpi_host

// file: verif/tb.sv
// Self-checking bench for the flash bus pin interface.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        addr_valid_n = 1'b1;
  logic        write_prot_n = 1'b1;
  logic        reset_n = 1'b1;
  logic        bus_clk = 1'b0;
  logic        clk_fall_sel = 1'b0;
  logic        sync_mode = 1'b0;
  logic [15:0] array_data = 16'h5a5a;
  logic [22:0] addr, array_addr, wr_addr;
  logic [15:0] data_in, data_out, wr_data;
  logic        chip_en_n, out_en_n, write_en_n, data_oe, wr_strobe, lockdown_ok, active, wait_out, wait_oe;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n_str = 0;
  // Row bits: chip enable, output enable, reset pin, expected drive, expected active.
  logic [4:0]  rows [5] = '{5'h07, 5'h0d, 5'h14, 5'h1c, 5'h00};
  initial forever #4 clock = ~clock;
  always @(posedge clock) if (wr_strobe === 1'b1) n_str <= n_str + 1;
  fbpi_host i_fbpi_host (.clock, .addr, .data_in, .chip_en_n, .out_en_n, .write_en_n);
  fbpi_top i_fbpi_top (.clock, .srst, .addr, .data_in, .data_out, .data_oe, .addr_valid_n, .chip_en_n,
    .out_en_n, .write_en_n, .write_prot_n, .reset_n, .bus_clk, .clk_fall_sel, .sync_mode, .array_data,
    .array_addr, .wr_addr, .wr_data, .wr_strobe, .lockdown_ok, .active, .wait_out, .wait_oe);
  task automatic chk(input logic [22:0] got, input logic [22:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    foreach (rows[i])
    begin
      reset_n <= rows[i][2];
      i_fbpi_host.sel(rows[i][4], rows[i][3]);
      repeat (3) @(posedge clock);
      chk(23'(data_oe), 23'(rows[i][1]), "data drive");
      chk(23'(wait_oe), 23'(rows[i][0]), "wait drive");
      chk(23'(active), 23'(rows[i][0]), "active");
    end
    $display("gating rows done");
    reset_n <= 1'b1;
    i_fbpi_host.sel(1'b0, 1'b0);
    repeat (3) @(posedge clock);
    chk(23'(data_out), 23'h005a5a, "read data");
    i_fbpi_host.wr(23'h7abcde, 16'hbeef);
    chk(wr_addr, 23'h7abcde, "write address");
    chk(23'(wr_data), 23'h00beef, "write data");
    chk(23'(n_str), 23'h000001, "one strobe");
    reset_n <= 1'b0;
    i_fbpi_host.wr(23'h000001, 16'h1234);
    chk(23'(n_str), 23'h000001, "write in reset");
    write_prot_n <= 1'b0;
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk(23'(lockdown_ok), 23'h000000, "lockdown guard");
    chk(array_addr, 23'h000001, "async read after reset");
    $display("write tests done");
    sync_mode <= 1'b1;
    i_fbpi_host.sel(1'b0, 1'b0);
    addr_valid_n <= 1'b0;
    repeat (3) @(posedge clock);
    addr_valid_n <= 1'b1;
    i_fbpi_host.adr(23'h000055);
    repeat (3) @(posedge clock);
    chk(array_addr, 23'h000001, "address latch");
    chk(23'(wait_out), 23'h000000, "wait before latency");
    repeat (8)
    begin
      repeat (2) @(posedge clock);
      bus_clk <= ~bus_clk;
    end
    repeat (3) @(posedge clock);
    chk(array_addr, 23'h000003, "counter advance");
    chk(23'(wait_out), 23'h000001, "wait on valid data");
    i_fbpi_host.wr(23'h000400, 16'h0003);
    chk(23'(wait_out), 23'h000000, "wait polarity flipped");
    chk(23'(n_str), 23'h000002, "second strobe");
    $display("sync read done");
    clk_fall_sel <= 1'b1;
    addr_valid_n <= 1'b0;
    bus_clk <= 1'b1;
    i_fbpi_host.adr(23'h2468ac);
    i_fbpi_host.adr(23'h13579b);
    bus_clk <= 1'b0;
    repeat (3) @(posedge clock);
    addr_valid_n <= 1'b1;
    i_fbpi_host.adr(23'h000077);
    repeat (3) @(posedge clock);
    chk(array_addr, 23'h13579b, "latch on falling clock");
    chk(23'(wait_out), 23'h000001, "wait idle with low polarity");
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk(23'(wait_out), 23'h000000, "wait polarity after reset");
    $display("falling edge done");
    results();
  end
endmodule // tb
